/* tch_consts.svh */
//==============================================================
// tape controller host interface constants
// Purpose: offsets, field positions and codes as macros
// Assumes: word registers, byte offset = 2 x index
// Notes:   definitions only
//
// Overview of operation
// - two transports, commands routed to selected one
// - six registers, four read/write, two read-only
// - pack tape bytes to words, unpack for writing
// - data words move by non-processor bus mastering
// - interrupt when ready or error present
// - issue select, direction, rewind, space, file-mark
// - monitor transport, flag errors, status readable
// - unused and write-only bits read zero
// - writes to read-only bits ignored
// - bus initialize clears controller and transports
// - command bit 12 clears controller and transports
// - base address set by jumpers
// - clear selects unit 0, rewind continues
// - command write while busy flags illegal command
`ifndef TCH_CONSTS_SVH
`define TCH_CONSTS_SVH
// register index, address bits 3:1 above base
`define TCH_IDX_STAT 3'h0
`define TCH_IDX_CMD  3'h1
`define TCH_IDX_BRC  3'h2
`define TCH_IDX_CMA  3'h3
`define TCH_IDX_DBUF 3'h4
`define TCH_IDX_RDL  3'h5
// command register fields
`define TCH_CMD_GO   0
`define TCH_CMD_FN   1
`define TCH_CMD_EXT  4
`define TCH_CMD_IE   6
`define TCH_CMD_PCLR 12
`define TCH_CMD_WMASK 16'h097E
// function codes
`define TCH_FN_OFFL 3'h0
`define TCH_FN_READ 3'h1
`define TCH_FN_WRT  3'h2
`define TCH_FN_WEOF 3'h3
`define TCH_FN_WXG  3'h6
`define TCH_BASE_RST 14'h0000
`define TCH_WORD_STEP 18'h00002
`endif

/* tch_pkg.sv */
//==============================================================
// tape controller host interface types
// Purpose: carrier structs and state enum
// Assumes: 18-bit system bus addresses, 16-bit data
// Notes:   constants live in tch_consts.svh
package tch_pkg;
   // slave cycle from the system bus, one cycle per access
   typedef struct packed {
      logic [17:0] addr;
      logic        rd;
      logic        wr;
      logic [1:0]  be;
      logic [15:0] wdata;
   } tch_bus_req_s;
   // bus master request toward memory
   typedef struct packed {
      logic        req;
      logic        write;
      logic [17:0] addr;
      logic [15:0] wdata;
   } tch_dma_req_s;
   // per transport status lines
   typedef struct packed {
      logic tur;
      logic selr;
      logic bot;
      logic eot;
      logic wrl;
      logic rws;
      logic sdwn;
   } tch_unit_stat_s;
   // shared tape data lines
   typedef struct packed {
      logic       rd_stb;
      logic       wr_stb;
      logic       eof;
      logic       crce;
      logic       pare;
      logic [7:0] data;
   } tch_tape_in_s;
   // commands to transports
   typedef struct packed {
      logic       unit;
      logic       go;
      logic [2:0] fn;
      logic       clear;
      logic       wr_en;
      logic       pevn;
      logic [7:0] wdata;
   } tch_tport_cmd_s;
   typedef enum logic [1:0] {
      TCH_ST_IDLE = 2'b00,
      TCH_ST_ARM  = 2'b01,
      TCH_ST_RUN  = 2'b10
   } tch_state_e;
endpackage : tch_pkg

/* tch_host_if.sv */
//==============================================================
// tape controller host interface
// Purpose: register bank, transfer engine and transport control
// Assumes: bus and memory handshakes are on i_clk; tape pins not
// Notes:   unmapped addresses get no ack, like a bus timeout
`timescale 1ns/1ps
`include "tch_consts.svh"
module tch_host_if (
   input  wire logic                       i_clk,
   input  wire logic                       i_rst_n,
   input  wire logic                       i_bus_init,
   input  wire logic [13:0]                i_base_jumpers,
   input  wire tch_pkg::tch_bus_req_s      i_bus,
   output logic [15:0]                     o_bus_rdata,
   output logic                            o_bus_ack,
   output logic                            o_intr_req,
   output tch_pkg::tch_dma_req_s           o_dma,
   input  wire logic                       i_dma_ack,
   input  wire logic [15:0]                i_dma_rdata,
   input  wire tch_pkg::tch_unit_stat_s    i_unit0,
   input  wire tch_pkg::tch_unit_stat_s    i_unit1,
   input  wire tch_pkg::tch_tape_in_s      i_tape,
   output tch_pkg::tch_tport_cmd_s         o_tport
);
   //==============================================================
   // pin synchronisers
   localparam int SW = 41;
   logic [SW-1:0] sync1_q;                  // first stage, read by stage two only
   logic [SW-1:0] sync2_q;                  // usable copy
   logic [1:0]    stb_prev_q;               // strobe history for edges
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1_q    <= '0;
         sync2_q    <= '0;
         stb_prev_q <= 2'h0;
      end else begin
         sync1_q    <= {i_base_jumpers, i_unit1, i_unit0, i_tape};
         sync2_q    <= sync1_q;
         // bit 12 is the read strobe, bit 11 the write strobe
         stb_prev_q <= {sync2_q[12], sync2_q[11]};
      end
   end
   tch_pkg::tch_tape_in_s   tape_s;
   tch_pkg::tch_unit_stat_s unit_s [2];
   logic [13:0]             base_s;         // jumper base, address bits 17:4
   assign tape_s    = sync2_q[12:0];
   assign unit_s[0] = sync2_q[19:13];
   assign unit_s[1] = sync2_q[26:20];
   assign base_s    = sync2_q[40:27];
   logic rd_edge;                           // tape read character
   logic wr_edge;                           // tape write character request
   assign rd_edge = tape_s.rd_stb & ~stb_prev_q[1];
   assign wr_edge = tape_s.wr_stb & ~stb_prev_q[0];

   //==============================================================
   // helpers
   function automatic logic [15:0] merge(input logic [15:0] old_v,
                                         input logic [15:0] new_v,
                                         input logic [1:0]  be,
                                         input logic [15:0] wmask);
      logic [15:0] m;
      m = {{8{be[1]}}, {8{be[0]}}} & wmask;
      return (old_v & ~m) | (new_v & m);
   endfunction : merge
   function automatic logic is_write_fn(input logic [2:0] fn);
      return (fn == `TCH_FN_WRT) || (fn == `TCH_FN_WXG);
   endfunction : is_write_fn

   //==============================================================
   // controller state
   tch_pkg::tch_state_e st_q, st_d;
   logic        unit_q, unit_d;             // selected transport
   logic [2:0]  fn_q, fn_d;                 // function code
   logic [1:0]  ext_q, ext_d;               // address bits 17:16
   logic        ie_q, ie_d;                 // interrupt enable
   logic        pevn_q, pevn_d;             // even parity sense
   logic [15:0] brc_q, brc_d;               // negative byte count
   logic [15:0] cma_q, cma_d;               // memory address
   logic [15:0] dbuf_q, dbuf_d;             // data word buffer
   logic        half_q, half_d;             // high byte next
   logic        pend_q, pend_d;             // memory cycle outstanding
   logic        dwr_q, dwr_d;               // pending cycle writes memory
   logic        ilc_q, ilc_d;
   logic        eof_q, eof_d;
   logic        cre_q, cre_d;
   logic        pae_q, pae_d;
   logic        bgl_q, bgl_d;
   logic        rle_q, rle_d;
   logic [15:0] rdata_q, rdata_d;
   logic        ack_q, ack_d;
   logic        go_q, go_d;                 // one-cycle start to transport
   logic        clr_q, clr_d;               // one-cycle clear to transport
   logic        wen_q, wen_d;
   logic [7:0]  wdat_q, wdat_d;

   // decoded views
   tch_pkg::tch_unit_stat_s sel;            // status of selected unit
   logic        controller_ready;
   logic        err;
   logic [15:0] stat;
   logic        hit;
   logic [2:0]  idx;
   logic [15:0] cmd_rd;
   logic [17:0] next_addr;
   assign sel    = unit_s[unit_q];
   assign controller_ready = (st_q == tch_pkg::TCH_ST_IDLE);
   assign err    = ilc_q | eof_q | cre_q | pae_q | bgl_q | rle_q | sel.eot;
   // status: errors, then monitored transport lines
   assign stat   = {ilc_q, eof_q, cre_q, pae_q, bgl_q, sel.eot, rle_q, 2'b00,
                    sel.selr, sel.bot, 1'b0, sel.sdwn, sel.wrl, sel.rws, sel.tur};
   assign idx    = i_bus.addr[3:1];
   // base from jumpers, six words above it
   assign hit    = (i_bus.rd | i_bus.wr) && (i_bus.addr[17:4] == base_s) && (idx <= `TCH_IDX_RDL);
   // go and clear read as zero
   assign cmd_rd = {err, 3'b000, pevn_q, 2'b00, unit_q, controller_ready, ie_q, ext_q, fn_q, 1'b0};
   assign next_addr = {ext_q, cma_q} + `TCH_WORD_STEP;

   // next-state logic for the whole controller
   always_comb begin
      logic        clear;
      logic [15:0] c_new;
      logic [2:0]  fn_new;
      logic        u_new;
      clear  = 1'b0;
      c_new  = merge(cmd_rd, i_bus.wdata, i_bus.be, `TCH_CMD_WMASK);
      fn_new = c_new[3:1];
      u_new  = c_new[8];
      st_d = st_q;  unit_d = unit_q;  fn_d = fn_q;  ext_d = ext_q;
      ie_d = ie_q;  pevn_d = pevn_q;  brc_d = brc_q;  cma_d = cma_q;
      dbuf_d = dbuf_q;  half_d = half_q;  pend_d = pend_q;  dwr_d = dwr_q;
      ilc_d = ilc_q;  eof_d = eof_q;  cre_d = cre_q;  pae_d = pae_q;
      bgl_d = bgl_q;  rle_d = rle_q;  wdat_d = wdat_q;
      go_d = 1'b0;  clr_d = 1'b0;  ack_d = hit;  rdata_d = rdata_q;
      // reads answer next cycle, never stall on tape
      if (hit && i_bus.rd) begin
         unique case (idx)
            `TCH_IDX_STAT: rdata_d = stat;
            `TCH_IDX_CMD:  rdata_d = cmd_rd;
            `TCH_IDX_BRC:  rdata_d = brc_q;
            `TCH_IDX_CMA:  rdata_d = cma_q;
            `TCH_IDX_DBUF: rdata_d = dbuf_q;
            default:       rdata_d = {8'h00, tape_s.data};  // read lines
         endcase
      end
      // ---- tape side activity
      if (!controller_ready) begin
         // transport dropping off line mid-operation
         if (!sel.selr && fn_q != `TCH_FN_OFFL) ilc_d = 1'b1;
         if (tape_s.eof)  eof_d = 1'b1;
         if (tape_s.crce) cre_d = 1'b1;
         if (tape_s.pare) pae_d = 1'b1;
         if (st_q == tch_pkg::TCH_ST_ARM && !sel.tur) st_d = tch_pkg::TCH_ST_RUN;
         // read: pack two tape bytes into one word
         if (fn_q == `TCH_FN_READ && rd_edge && !bgl_q && !rle_q) begin
            if (pend_q) begin
               bgl_d = 1'b1;                               // grant came too late
            end else if (brc_q == 16'h0000) begin
               rle_d = 1'b1;
            end else begin
               brc_d = brc_q + 16'h0001;
               if (half_q) begin
                  dbuf_d[15:8] = tape_s.data;
                  pend_d = 1'b1;
                  dwr_d  = 1'b1;
               end else begin
                  dbuf_d[7:0] = tape_s.data;
               end
               half_d = ~half_q;
            end
         end
         // write: unpack a fetched word, low byte first
         if (is_write_fn(fn_q) && wr_edge && !bgl_q && brc_q != 16'h0000) begin
            if (pend_q) begin
               bgl_d = 1'b1;
            end else begin
               wdat_d = half_q ? dbuf_q[15:8] : dbuf_q[7:0];
               brc_d  = brc_q + 16'h0001;
               half_d = ~half_q;
               if (half_q && brc_q != 16'hFFFF) begin
                  pend_d = 1'b1;
                  dwr_d  = 1'b0;
               end
            end
         end
         // memory cycle finished
         if (pend_q && i_dma_ack) begin
            pend_d = 1'b0;
            {ext_d, cma_d} = next_addr;
            if (!dwr_q) dbuf_d = i_dma_rdata;
         end
         // transport ready again ends the operation
         if (st_q == tch_pkg::TCH_ST_RUN && sel.tur) begin
            if (fn_q == `TCH_FN_READ && half_q && !pend_q) begin
               pend_d = 1'b1;                              // flush odd byte
               dwr_d  = 1'b1;
               half_d = 1'b0;
            end else if (!pend_q || bgl_q) begin
               st_d   = tch_pkg::TCH_ST_IDLE;
               pend_d = 1'b0;
            end
         end
      end
      // ---- register writes
      if (hit && i_bus.wr) begin
         unique case (idx)
            `TCH_IDX_CMD: begin
               if (!controller_ready) begin
                  ilc_d = 1'b1;                            // busy, refused
               end else begin
                  // only writable fields change
                  fn_d = fn_new;  unit_d = u_new;  ext_d = c_new[5:4];
                  ie_d = c_new[`TCH_CMD_IE];  pevn_d = c_new[11];
                  if (i_bus.be[0] && i_bus.wdata[`TCH_CMD_GO]) begin
                     {ilc_d, eof_d, cre_d, pae_d, bgl_d, rle_d} = 6'h00;
                     if (!unit_s[u_new].selr ||
                         (is_write_fn(fn_new) || fn_new == `TCH_FN_WEOF) && unit_s[u_new].wrl) begin
                        ilc_d = 1'b1;
                     end else begin
                        go_d   = 1'b1;
                        st_d   = tch_pkg::TCH_ST_ARM;
                        half_d = 1'b0;
                        pend_d = is_write_fn(fn_new);      // prefetch first word
                        dwr_d  = 1'b0;
                     end
                  end
               end
               if (i_bus.be[1] && i_bus.wdata[`TCH_CMD_PCLR]) clear = 1'b1;
            end
            `TCH_IDX_BRC:  brc_d  = merge(brc_q, i_bus.wdata, i_bus.be, 16'hFFFF);
            `TCH_IDX_CMA:  cma_d  = merge(cma_q, i_bus.wdata, i_bus.be, 16'hFFFF);
            `TCH_IDX_DBUF: dbuf_d = merge(dbuf_q, i_bus.wdata, i_bus.be, 16'hFFFF);
            default: ;                                     // read-only
         endcase
      end
      // ---- controller clear from bus or command bit
      if (clear || i_bus_init) begin
         st_d = tch_pkg::TCH_ST_IDLE;
         unit_d = 1'b0;                                    // unit 0
         fn_d = `TCH_FN_OFFL;  ext_d = 2'h0;  ie_d = 1'b0;  pevn_d = 1'b0;
         brc_d = 16'h0000;  cma_d = 16'h0000;  dbuf_d = 16'h0000;
         half_d = 1'b0;  pend_d = 1'b0;  dwr_d = 1'b0;  go_d = 1'b0;
         {ilc_d, eof_d, cre_d, pae_d, bgl_d, rle_d} = 6'h00;
         clr_d = 1'b1;                                     // transports keep rewinding
      end
      wen_d = (st_d != tch_pkg::TCH_ST_IDLE) && is_write_fn(fn_d) && !bgl_d;
   end

   // register the controller state
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_q <= tch_pkg::TCH_ST_IDLE;
         unit_q <= 1'b0;  fn_q <= 3'h0;  ext_q <= 2'h0;  ie_q <= 1'b0;
         pevn_q <= 1'b0;  brc_q <= 16'h0000;  cma_q <= 16'h0000;
         dbuf_q <= 16'h0000;  half_q <= 1'b0;  pend_q <= 1'b0;  dwr_q <= 1'b0;
         ilc_q <= 1'b0;  eof_q <= 1'b0;  cre_q <= 1'b0;  pae_q <= 1'b0;
         bgl_q <= 1'b0;  rle_q <= 1'b0;  rdata_q <= 16'h0000;  ack_q <= 1'b0;
         go_q <= 1'b0;  clr_q <= 1'b0;  wen_q <= 1'b0;  wdat_q <= 8'h00;
      end else begin
         st_q <= st_d;
         unit_q <= unit_d;  fn_q <= fn_d;  ext_q <= ext_d;  ie_q <= ie_d;
         pevn_q <= pevn_d;  brc_q <= brc_d;  cma_q <= cma_d;
         dbuf_q <= dbuf_d;  half_q <= half_d;  pend_q <= pend_d;  dwr_q <= dwr_d;
         ilc_q <= ilc_d;  eof_q <= eof_d;  cre_q <= cre_d;  pae_q <= pae_d;
         bgl_q <= bgl_d;  rle_q <= rle_d;  rdata_q <= rdata_d;  ack_q <= ack_d;
         go_q <= go_d;  clr_q <= clr_d;  wen_q <= wen_d;  wdat_q <= wdat_d;
      end
   end

   //==============================================================
   // outputs
   assign o_bus_rdata = rdata_q;
   assign o_bus_ack   = ack_q;
   assign o_intr_req  = ie_q & (controller_ready | err);
   assign o_dma       = '{req: pend_q, write: dwr_q, addr: {ext_q, cma_q}, wdata: dbuf_q};
   assign o_tport     = '{unit: unit_q, go: go_q, fn: fn_q, clear: clr_q,
                          wr_en: wen_q, pevn: pevn_q, wdata: wdat_q};

   //==============================================================
   // assertions
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_go_pulse;
      o_tport.go ##1 !o_tport.go;
   endsequence
   a_busy_write_flag: assert property (hit && i_bus.wr && idx == `TCH_IDX_CMD && !controller_ready && !i_bus_init
      |=> ilc_q && err)
      else $error("busy command write not flagged");
   a_clear_unit_zero: assert property (i_bus_init |=> o_tport.unit == 1'b0 && o_tport.clear && controller_ready)
      else $error("clear did not select unit 0");
   a_local_clear: assert property (hit && i_bus.wr && idx == `TCH_IDX_CMD && i_bus.be[1]
      && i_bus.wdata[`TCH_CMD_PCLR] |=> o_tport.clear && !ilc_q ##1 !o_tport.clear)
      else $error("local clear not applied");
   a_read_zero_bits: assert property (hit && i_bus.rd && idx == `TCH_IDX_CMD
      |=> o_bus_rdata[`TCH_CMD_PCLR] == 1'b0 && o_bus_rdata[`TCH_CMD_GO] == 1'b0)
      else $error("write-only command bits read nonzero");
   a_base_decode: assert property ((i_bus.rd || i_bus.wr) && i_bus.addr[17:4] != base_s
      |=> !o_bus_ack)
      else $error("ack outside jumper base");
   a_ack_one_cycle: assert property (hit |=> o_bus_ack)
      else $error("register cycle not answered next cycle");
   a_intr_ready: assert property (ie_q && controller_ready |-> o_intr_req)
      else $error("ready without interrupt request");
   a_go_starts_op: assert property (s_go_pulse |-> !controller_ready)
      else $error("start pulse without busy controller");
   a_dma_step: assert property (o_dma.req && i_dma_ack && !controller_ready && !i_bus_init && !(hit && i_bus.wr)
      |=> {ext_q, cma_q} == $past(next_addr) && !o_dma.req)
      else $error("memory address did not step by one word");
   a_word_packed: assert property (fn_q == `TCH_FN_READ && !controller_ready && rd_edge && half_q && !pend_q
      && brc_q != 16'h0000 && !bgl_q && !rle_q && !i_bus_init
      |=> o_dma.req && o_dma.write)
      else $error("full word not sent to memory");
endmodule : tch_host_if

/* tch_mem_model.sv */
//==============================================================
// Purpose: memory behind the controller's bus master port
// Assumes: one request outstanding, answered after i_wait cycles
// Notes:   idle read data toggles so stale values never match
`timescale 1ns/1ps
module tch_mem_model (
   input  wire logic                  i_clk,
   input  wire logic [3:0]            i_wait,
   input  wire tch_pkg::tch_dma_req_s i_dma,
   output logic                       o_ack,
   output logic [15:0]                o_rdata
);
   logic [15:0] mem [0:255]; // word store, address bits 8:1
   int          wait_n;      // cycles the request has waited
   initial begin
      o_ack = 1'b0;
      o_rdata = 16'h0000;
      wait_n = 0;
   end
   // one-cycle ack after the wait, data moved with it
   always @(negedge i_clk) begin
      if (i_dma.req === 1'b1 && !o_ack && wait_n >= i_wait) begin
         o_ack <= 1'b1;
         wait_n <= 0;
         if (i_dma.write) mem[i_dma.addr[8:1]] <= i_dma.wdata;
         else o_rdata <= mem[i_dma.addr[8:1]];
      end else begin
         // released bus: data no longer valid, show a moving pattern
         o_ack <= 1'b0;
         o_rdata <= ~o_rdata;
         wait_n <= (i_dma.req === 1'b1) ? wait_n + 1 : 0;
      end
   end
endmodule : tch_mem_model

/* test_tape_controller_host_interface.sv */
//==============================================================
// Purpose: self-checking bench for the tape controller host side
// Assumes: bus and tape stimulus change at the falling edge
// Notes:   transport status and tape bytes are driven by hand
`timescale 1ns/1ps
module test_tape_controller_host_interface;
   logic                     clk;
   logic                     rst_n;
   logic                     bus_init;
   logic [13:0]              base;
   tch_pkg::tch_bus_req_s    bus;
   logic [15:0]              rdata;
   logic                     ack;
   logic                     intr;
   tch_pkg::tch_dma_req_s    dma;
   logic                     dma_ack;
   logic [15:0]              dma_rdata;
   tch_pkg::tch_unit_stat_s  u0;
   tch_pkg::tch_unit_stat_s  u1;
   tch_pkg::tch_tape_in_s    tape;
   tch_pkg::tch_tport_cmd_s  tp;
   logic [15:0]              rv;      // last read data
   int                       err_count;
   int                       cmp_count;
   int                       go_n;    // go pulses seen
   int                       clr_n;   // clear pulses seen
   int                       ack_n;   // memory acks seen

   tch_host_if dut (.i_clk(clk), .i_rst_n(rst_n), .i_bus_init(bus_init), .i_base_jumpers(base),
      .i_bus(bus), .o_bus_rdata(rdata), .o_bus_ack(ack), .o_intr_req(intr), .o_dma(dma),
      .i_dma_ack(dma_ack), .i_dma_rdata(dma_rdata), .i_unit0(u0), .i_unit1(u1), .i_tape(tape),
      .o_tport(tp));
   tch_mem_model mem (.i_clk(clk), .i_wait(4'h2), .i_dma(dma), .o_ack(dma_ack), .o_rdata(dma_rdata));

   // 40 MHz clock
   always #12.5 clk = ~clk;
   // pulse counters, sampled where outputs are settled
   always @(negedge clk) begin
      if (tp.go === 1'b1) go_n++;
      if (tp.clear === 1'b1) clr_n++;
      if (dma_ack === 1'b1) ack_n++;
   end

   //==============================================================
   // shared tasks
   task automatic final_report;
      if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // one slave cycle; ack is registered on the taking edge and sampled at the next falling edge
   task automatic acc(input logic w, input logic [2:0] idx, input logic [1:0] be,
                      input logic [15:0] wd, input logic [13:0] b, output logic got);
      @(negedge clk);
      bus = '{addr: {b, idx, 1'b0}, rd: !w, wr: w, be: be, wdata: wd};
      @(negedge clk);
      bus.rd = 1'b0;
      bus.wr = 1'b0;
      got = ack;
      rv = rdata;
   endtask : acc
   task automatic rd(input logic [2:0] idx);
      logic g;
      acc(1'b0, idx, 2'b11, 16'h0000, base, g);
      chk({15'h0000, g}, 16'h0001);
   endtask : rd
   task automatic wr(input logic [2:0] idx, input logic [15:0] v, input logic [1:0] be);
      logic g;
      acc(1'b1, idx, be, v, base, g);
      chk({15'h0000, g}, 16'h0001);
   endtask : wr
   // one tape character strobe, read or write, held long enough for the syncs
   task automatic tape_byte(input logic w, input logic [7:0] b);
      tape.data = b;
      repeat (2) @(negedge clk);
      if (w) tape.wr_stb = 1'b1;
      else tape.rd_stb = 1'b1;
      repeat (4) @(negedge clk);
      tape.rd_stb = 1'b0;
      tape.wr_stb = 1'b0;
      repeat (4) @(negedge clk);
   endtask : tape_byte

   //==============================================================
   // scenarios
   task automatic t_regs;
      rd(0); chk(rv, 16'h0041);
      rd(1); chk(rv, 16'h0080);
      wr(1, 16'hE97E, 2'b11);
      rd(1); chk(rv, 16'h09FE);
      chk({15'h0000, tp.unit}, 16'h0001);
      chk({15'h0000, tp.pevn}, 16'h0001);
      chk({15'h0000, intr}, 16'h0001);
      wr(0, 16'hFFFF, 2'b11);
      rd(0); chk(rv, 16'h0001);
      wr(1, 16'h0000, 2'b01);
      rd(1); chk(rv, 16'h0980);
      chk({15'h0000, intr}, 16'h0000);
      wr(4, 16'hA55A, 2'b11);
      rd(4); chk(rv, 16'hA55A);
      wr(5, 16'hFFFF, 2'b11);
      rd(5); chk(rv, 16'h0000);
   endtask : t_regs
   // go to an offline unit is refused, then a local clear
   task automatic t_offline_clear;
      int g;
      int c;
      g = go_n;
      wr(1, 16'h0103, 2'b11);
      repeat (4) @(negedge clk);
      chk(go_n[15:0], g[15:0]);
      rd(1); chk(rv, 16'h8182);
      c = clr_n;
      wr(1, 16'h1100, 2'b10);
      repeat (3) @(negedge clk);
      chk(clr_n[15:0], c[15:0] + 16'h0001);
      chk({15'h0000, tp.unit}, 16'h0000);
      rd(1); chk(rv, 16'h0080);
      rd(0); chk(rv, 16'h0041);
   endtask : t_offline_clear
   // two tape bytes packed into one memory write, then an illegal command
   task automatic t_read;
      int a;
      int i;
      wr(2, 16'hFFFE, 2'b11);
      wr(3, 16'h0100, 2'b11);
      a = go_n;
      wr(1, 16'h0043, 2'b11);
      repeat (3) @(negedge clk);
      chk(go_n[15:0], a[15:0] + 16'h0001);
      chk({13'h0000, tp.fn}, 16'h0001);
      rd(1); chk(rv, 16'h0042);
      u0.tur = 1'b0;
      repeat (4) @(negedge clk);
      a = ack_n;
      tape_byte(1'b0, 8'h34);
      tape_byte(1'b0, 8'h12);
      for (i = 0; i < 40 && ack_n == a; i++) @(negedge clk);
      if (ack_n == a) begin
         err_count++;
         final_report();
      end
      repeat (2) @(negedge clk);
      chk(mem.mem[8'h80], 16'h1234);
      chk({15'h0000, dma.req}, 16'h0000);
      rd(3); chk(rv, 16'h0102);
      rd(2); chk(rv, 16'h0000);
      wr(1, 16'h0000, 2'b11);
      rd(1); chk(rv, 16'h8042);
      chk({15'h0000, intr}, 16'h0001);
      u0.tur = 1'b1;
      for (i = 0; i < 20; i++) begin
         rd(1);
         if (rv[7] === 1'b1) break;
      end
      if (i == 20) begin
         err_count++;
         final_report();
      end
      chk(rv, 16'h80C2);
   endtask : t_read
   // word fetched from memory, sent to tape low byte first
   task automatic t_write;
      wr(2, 16'hFFFE, 2'b11);
      wr(3, 16'h0100, 2'b11);
      wr(1, 16'h0045, 2'b11);
      u0.tur = 1'b0;
      repeat (8) @(negedge clk);
      rd(4); chk(rv, 16'h1234);
      rd(3); chk(rv, 16'h0102);
      chk({15'h0000, tp.wr_en}, 16'h0001);
      tape_byte(1'b1, 8'h00);
      chk({8'h00, tp.wdata}, 16'h0034);
      tape_byte(1'b1, 8'h00);
      chk({8'h00, tp.wdata}, 16'h0012);
      rd(2); chk(rv, 16'h0000);
      u0.tur = 1'b1;
      repeat (4) @(negedge clk);
      chk({15'h0000, tp.wr_en}, 16'h0000);
      rd(1); chk(rv, 16'h00C4);
   endtask : t_write
   task automatic t_init;
      wr(1, 16'h0100, 2'b10);
      wr(2, 16'h1234, 2'b11);
      bus_init = 1'b1;
      @(negedge clk);
      bus_init = 1'b0;
      repeat (2) @(negedge clk);
      chk({15'h0000, tp.unit}, 16'h0000);
      rd(1); chk(rv, 16'h0080);
      rd(2); chk(rv, 16'h0000);
   endtask : t_init
   task automatic t_decode;
      logic g;
      acc(1'b0, 3'h6, 2'b11, 16'h0000, base, g);
      chk({15'h0000, g}, 16'h0000);
      base = 14'h0ABC;
      repeat (4) @(negedge clk);
      acc(1'b0, 3'h1, 2'b11, 16'h0000, 14'h1EA5, g);
      chk({15'h0000, g}, 16'h0000);
      rd(1); chk(rv, 16'h0080);
   endtask : t_decode

   //==============================================================
   // main sequence
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      bus_init = 1'b0;
      bus = '0;
      base = 14'h1EA5;
      u0 = '{tur: 1'b1, selr: 1'b1, default: 1'b0};
      u1 = '{tur: 1'b1, default: 1'b0};
      tape = '0;
      err_count = 0;
      cmp_count = 0;
      go_n = 0;
      clr_n = 0;
      ack_n = 0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      t_regs();
      t_offline_clear();
      t_read();
      t_write();
      t_init();
      t_decode();
      final_report();
   end
endmodule : test_tape_controller_host_interface
